// File: src/oc_channel_defines.vh
// Constants for the timer compare channel: register map, field positions,
// channel modes and reset values.
// Assumes a 32-bit APB slave with byte addresses on PADDR.
`ifndef OC_CHANNEL_DEFINES_VH
`define OC_CHANNEL_DEFINES_VH

// ============================================================
// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_COMPARE   8'h04
`define OFS_RELOAD    8'h08
`define OFS_COUNT     8'h0C
`define OFS_STATUS    8'h10
`define OFS_EVENT     8'h14

// ============================================================
// Control register fields
`define CT_MODE_LO    0
`define CT_MODE_HI    2
`define CT_PRELOAD    3
`define CT_FAST       4
`define CT_CLREN      5
`define CT_IRQEN      6
`define CT_CAS_LO     7
`define CT_CAS_HI     8
`define CT_DIR        9
`define CT_ONEP       10
`define CT_ARPE       11
`define CT_CNTEN      12
`define CT_POL        13
`define CT_OEN        14

// Status and event fields
`define ST_FLAG       0
`define ST_HOLD       1
`define ST_REF        2
`define EV_UPDATE     0
`define EV_TRIGGER    1

// ============================================================
// Channel modes
`define MD_FROZEN     3'h0
`define MD_SET        3'h1
`define MD_CLEAR      3'h2
`define MD_TOGGLE     3'h3
`define MD_FORCE_LO   3'h4
`define MD_FORCE_HI   3'h5
`define MD_PWM1       3'h6
`define MD_PWM2       3'h7

// Center-align select codes
`define CAS_EDGE      2'h0
`define CAS_DOWN      2'h1
`define CAS_UP        2'h2

// Reset values
`define RST_CTRL      15'h0000
`define RST_RELOAD    16'hFFFF

`endif

// File: src/oc_channel.v
// Timer compare channel with its own counter base and APB register slave.
// Assumes one 200 MHz clock REF_CLK, synchronous active-low RSTN, and
// trigger pins from outside the clock domain.
//
// Operation
// RQ1: Mode 101 forces the reference high; pin shows inverse of polarity.
// RQ2: Mode 100 forces the reference low.
// RQ3: Forced modes still compare and set the match flag.
// RQ4: On match, mode 000 keeps, 001 sets, 010 clears, 011 toggles.
// RQ5: Match sets the flag; interrupt raised when enable bit set.
// RQ6: Preload clear: compare write immediate; set: load on update.
// RQ7: Modes 110 and 111 are PWM 1 and 2; duty compare, period reload.
// RQ8: Preload values reach shadows only on update; software generates one first.
// RQ9: Nonzero center select enables center PWM; 01 down, 10 up, 11 both.
// RQ10: Hardware owns direction in center mode; software leaves it alone.
// RQ11: Center mode count write of 0 or reload sets direction, no update.
// RQ12: Edge mode counts up when direction is 0, down when 1.
// RQ13: Up PWM1 high while count below compare; compare 0 gives constant low.
// RQ14: Down PWM1 low while count above compare; high if compare beyond reload.
// RQ15: Down counting, compare falling from reload-or-more to 0 gives no event.
// RQ16: Single pulse mode stops the counter at the update event.
// RQ17: Single pulse uses compare or PWM mode; delay compare, width reload minus.
// RQ18: Fast enable: trigger edge drives match level at once, PWM only.
// RQ19: Clear enable: high filtered trigger holds reference low until update. The code leaves forced modes 100 and 101 alone.
// RQ20: Software sets up the external trigger path before using clear.
// RQ21: PWM with preload needs both preload enable bits set.
// RQ22: Counter, direction and update feed the channel; reference goes to output.
//
// Added by the designer: the register offsets and the APB register port.
`include "oc_channel_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module oc_channel #(
    parameter W = 16
) (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        RSTN,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // Trigger pins
    input  wire        TRIG_IN,
    input  wire        EXT_TRIG_IN,
    // Channel outputs
    output reg         REF_WAVE,
    output reg         CHAN_OUT,
    output reg         CHAN_OUT_EN,
    output reg         MATCH_IRQ
);

    // ============================================================
    // Declarations
    reg  [14:0]  ctrl_reg;
    reg  [W-1:0] ccr_pre_reg;
    reg  [W-1:0] ccr_sh_reg;
    reg  [W-1:0] arr_pre_reg;
    reg  [W-1:0] arr_sh_reg;
    reg  [W-1:0] cnt_reg;
    reg  [W-1:0] cnt_next;
    reg          dir_reg;
    reg          dir_next;
    reg          run_reg;
    reg          run_next;
    reg          flag_reg;
    reg          hold_reg;
    reg          ge_reg;
    reg          ref_reg;
    reg          ref_next;
    reg          update_event;
    reg  [1:0]   trig_sync_reg;
    reg          trig_last_reg;
    reg  [1:0]   etr_sync_reg;
    reg  [31:0]  rdata;
    reg          hit;

    wire [2:0] mode   = ctrl_reg[`CT_MODE_HI:`CT_MODE_LO];
    wire [1:0] cas    = ctrl_reg[`CT_CAS_HI:`CT_CAS_LO];
    wire       center = (cas != `CAS_EDGE);
    wire       pwm    = (mode == `MD_PWM1) || (mode == `MD_PWM2);
    wire       forced = (mode == `MD_FORCE_LO) || (mode == `MD_FORCE_HI);

    // ============================================================
    // Bus decode: the access completes at the edge where PREADY is seen
    wire acc  = PSEL && PENABLE && PREADY;
    wire wr   = acc && PWRITE;
    wire w_ct = wr && (PADDR == `OFS_CTRL);
    wire w_cc = wr && (PADDR == `OFS_COMPARE);
    wire w_ar = wr && (PADDR == `OFS_RELOAD);
    wire w_cn = wr && (PADDR == `OFS_COUNT);
    wire w_st = wr && (PADDR == `OFS_STATUS);
    wire w_ev = wr && (PADDR == `OFS_EVENT);
    wire sw_upd  = w_ev && PWDATA[`EV_UPDATE];
    wire sw_trig = w_ev && PWDATA[`EV_TRIGGER];
    wire [W-1:0] wval = PWDATA[W-1:0];

    // Trigger edge from the pin or from software
    wire trig_edge = (trig_sync_reg[1] && !trig_last_reg) || sw_trig;
    wire etr_high  = etr_sync_reg[1];

    // ============================================================
    // PWM level for mode 1 or 2 at a given count; used for the running
    // waveform and for the level that fast enable jumps to.
    function pwm_level;
        input [2:0]   md;
        input         down;
        input [W-1:0] cnt;
        input [W-1:0] ccr;
        reg           lvl;
        begin
            if (down)
                lvl = !(cnt > ccr); // RQ14
            else
                lvl = (cnt < ccr);  // RQ13
            pwm_level = (md == `MD_PWM2) ? !lvl : lvl; // RQ7
        end
    endfunction

    // ============================================================
    // Pin synchronisers; first stage is read only by the second
    always @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            trig_sync_reg <= 2'h0;
            trig_last_reg <= 1'b0;
            etr_sync_reg  <= 2'h0;
        end
        else
        begin
            trig_sync_reg <= {trig_sync_reg[0], TRIG_IN};
            trig_last_reg <= trig_sync_reg[1];
            etr_sync_reg  <= {etr_sync_reg[0], EXT_TRIG_IN};
        end
    end

    // ============================================================
    // Counter base: next count, direction, run state and update event
    always @*
    begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        run_next = run_reg;
        update_event      = 1'b0;
        if (run_reg)
        begin
            if (center)
            begin
                // Direction turns at the ends, owned by hardware
                if (!dir_reg && cnt_reg >= arr_sh_reg) // RQ10
                begin
                    dir_next = 1'b1;
                    cnt_next = arr_sh_reg - {{(W-1){1'b0}}, 1'b1};
                    update_event      = 1'b1;
                end
                else if (dir_reg && cnt_reg == {W{1'b0}})
                begin
                    dir_next = 1'b0;
                    cnt_next = {{(W-1){1'b0}}, 1'b1};
                    update_event      = 1'b1;
                end
                else if (dir_reg)
                    cnt_next = cnt_reg - {{(W-1){1'b0}}, 1'b1};
                else
                    cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
            end
            else if (!dir_reg) // RQ12
            begin
                update_event      = (cnt_reg >= arr_sh_reg);
                cnt_next = update_event ? {W{1'b0}} : cnt_reg + {{(W-1){1'b0}}, 1'b1};
            end
            else
            begin
                update_event      = (cnt_reg == {W{1'b0}});
                cnt_next = update_event ? arr_sh_reg : cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
            if (update_event && ctrl_reg[`CT_ONEP])
                run_next = 1'b0; // RQ16
        end
        // Software count write overrides counting, no update event
        if (w_cn)
        begin
            cnt_next = wval;
            if (center && wval == {W{1'b0}})
                dir_next = 1'b0; // RQ11
            else if (center && wval == arr_sh_reg)
                dir_next = 1'b1; // RQ11
        end
        if (w_ct && PWDATA[`CT_CAS_HI:`CT_CAS_LO] == `CAS_EDGE)
            dir_next = PWDATA[`CT_DIR]; // RQ12
        // Software update restarts the count and loads the shadows
        if (sw_upd)
        begin
            update_event      = 1'b1; // RQ8
            cnt_next = (!center && dir_next) ? arr_pre_reg : {W{1'b0}};
        end
        if (w_ct)
            run_next = PWDATA[`CT_CNTEN];
        if (trig_edge)
            run_next = 1'b1;
    end

    // ============================================================
    // Compare match qualified by counting direction in center mode
    always @*
    begin
        hit = run_reg && (cnt_reg == ccr_sh_reg);
        if (cas == `CAS_DOWN && !dir_reg)
            hit = 1'b0; // RQ9
        if (cas == `CAS_UP && dir_reg)
            hit = 1'b0; // RQ9
        // A compare that dropped from reload-or-above to 0 makes no event while counting down
        if (dir_reg && ge_reg && ccr_sh_reg == {W{1'b0}})
            hit = 1'b0; // RQ15
    end

    // ============================================================
    // Reference waveform next value
    always @*
    begin
        ref_next = ref_reg;
        case (mode)
            `MD_FROZEN:   ref_next = ref_reg; // RQ4
            `MD_SET:      ref_next = hit ? 1'b1 : ref_reg; // RQ4
            `MD_CLEAR:    ref_next = hit ? 1'b0 : ref_reg; // RQ4
            `MD_TOGGLE:   ref_next = hit ? !ref_reg : ref_reg; // RQ4
            `MD_FORCE_LO: ref_next = 1'b0; // RQ2
            `MD_FORCE_HI: ref_next = 1'b1; // RQ1
            `MD_PWM1,
            `MD_PWM2:     ref_next = pwm_level(mode, dir_next, cnt_next, ccr_sh_reg); // RQ7
            default:      ref_next = ref_reg;
        endcase
        // Fast enable jumps to the up-counting after-match level on the trigger edge
        if (pwm && ctrl_reg[`CT_FAST] && trig_edge)
            ref_next = pwm_level(mode, 1'b0, ccr_sh_reg, ccr_sh_reg); // RQ18
        // External clear wins over every non-forced mode
        if (!forced && (hold_reg || (ctrl_reg[`CT_CLREN] && etr_high)))
            ref_next = 1'b0; // RQ19
    end

    // ============================================================
    // Counter, shadows and control state
    always @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            ctrl_reg    <= `RST_CTRL;
            ccr_pre_reg <= {W{1'b0}};
            ccr_sh_reg  <= {W{1'b0}};
            arr_pre_reg <= `RST_RELOAD;
            arr_sh_reg  <= `RST_RELOAD;
            cnt_reg     <= {W{1'b0}};
            dir_reg     <= 1'b0;
            run_reg     <= 1'b0;
            ge_reg      <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next; // RQ22
            dir_reg <= dir_next; // RQ22
            run_reg <= run_next;
            if (w_ct)
                ctrl_reg <= {PWDATA[`CT_OEN:`CT_CNTEN], ctrl_reg[`CT_ARPE:`CT_CNTEN-3],
                             PWDATA[`CT_DIR-1:0]} & 15'h7DFF | {5'h00, dir_next, 9'h000};
            else
                ctrl_reg <= {ctrl_reg[`CT_OEN:`CT_DIR+1], dir_next, ctrl_reg[`CT_DIR-1:0]};
            if (w_ct)
                ctrl_reg[`CT_ARPE:`CT_ONEP] <= PWDATA[`CT_ARPE:`CT_ONEP];
            if (w_cc)
                ccr_pre_reg <= wval;
            if (w_ar)
                arr_pre_reg <= wval;
            // Compare shadow: immediate without preload, else on update
            if (w_cc && !ctrl_reg[`CT_PRELOAD])
                ccr_sh_reg <= wval; // RQ6
            else if (update_event)
                ccr_sh_reg <= ccr_pre_reg; // RQ8
            if (w_ar && !ctrl_reg[`CT_ARPE])
                arr_sh_reg <= wval;
            else if (update_event)
                arr_sh_reg <= arr_pre_reg; // RQ8
            // Remember whether the old compare reached the reload value
            if (update_event)
                ge_reg <= (ccr_sh_reg >= arr_sh_reg); // RQ15
        end
    end

    // ============================================================
    // Match flag, clear hold, reference and pin outputs
    always @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            flag_reg    <= 1'b0;
            hold_reg    <= 1'b0;
            ref_reg     <= 1'b0;
            REF_WAVE    <= 1'b0;
            CHAN_OUT    <= 1'b0;
            CHAN_OUT_EN <= 1'b0;
            MATCH_IRQ   <= 1'b0;
        end
        else
        begin
            // Set wins over a software clear in the same cycle
            if (hit)
                flag_reg <= 1'b1; // RQ3 RQ5
            else if (w_st && PWDATA[`ST_FLAG])
                flag_reg <= 1'b0;
            // Hold ends on update, but a still-high trigger keeps it
            if (ctrl_reg[`CT_CLREN] && etr_high && !forced)
                hold_reg <= 1'b1; // RQ19
            else if (update_event || !ctrl_reg[`CT_CLREN])
                hold_reg <= 1'b0; // RQ19
            ref_reg     <= ref_next;
            REF_WAVE    <= ref_next; // RQ22
            CHAN_OUT    <= ctrl_reg[`CT_OEN] & (ref_next ^ ctrl_reg[`CT_POL]); // RQ1
            CHAN_OUT_EN <= ctrl_reg[`CT_OEN];
            MATCH_IRQ   <= (flag_reg || hit) && ctrl_reg[`CT_IRQEN]; // RQ5
        end
    end

    // ============================================================
    // Read mux; unmapped addresses read zero and answer with an error
    always @*
    begin
        rdata = 32'h0000_0000;
        case (PADDR)
            `OFS_CTRL:    rdata = {17'h00000, ctrl_reg};
            `OFS_COMPARE: rdata = {{(32-W){1'b0}}, ccr_pre_reg};
            `OFS_RELOAD:  rdata = {{(32-W){1'b0}}, arr_pre_reg};
            `OFS_COUNT:   rdata = {{(32-W){1'b0}}, cnt_reg};
            `OFS_STATUS:  rdata = {29'h0000_0000, ref_reg, hold_reg, flag_reg};
            `OFS_EVENT:   rdata = 32'h0000_0000;
            default:      rdata = 32'h0000_0000;
        endcase
    end

    // ============================================================
    // APB answer: one wait state, so PREADY comes from a flip-flop
    always @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PRDATA  <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rdata : 32'h0000_0000;
            PSLVERR <= PSEL && PENABLE && !PREADY && (PADDR > `OFS_EVENT || PADDR[1:0] != 2'h0);
        end
    end

endmodule // oc_channel

`default_nettype wire

// File: tb/oc_channel_monitor.sv
// Checker for the compare channel: APB timing, reset and forced levels.
// Assumes it is bound to oc_channel and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "oc_channel_defines.vh"
module oc_channel_monitor (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Channel
    input wire logic        REF_WAVE,
    input wire logic        CHAN_OUT,
    input wire logic        CHAN_OUT_EN
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // ==========
    // Control word copy and its age, so levels are judged once settled
    logic [14:0] ctrl_reg;
    logic [1:0]  age_reg;
    wire         wr_ctrl = PSEL && PENABLE && PREADY && PWRITE && PADDR == `OFS_CTRL;
    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            ctrl_reg <= 15'h0000;
            age_reg  <= 2'h0;
        end
        else if (wr_ctrl)
        begin
            ctrl_reg <= PWDATA[14:0];
            age_reg  <= 2'h0;
        end
        else if (age_reg != 2'h3)
            age_reg <= age_reg + 2'h1;
    end
    // ==========
    // Assertions
    pready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready not one cycle into access");
    pready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    slverr_map_a: assert property (PREADY |-> PSLVERR == (PADDR > 8'h14 || PADDR[1:0] != 2'h0))
        else $error("error response wrong");
    rdata_idle_a: assert property (!PREADY || PWRITE |-> PRDATA == 32'h0000_0000)
        else $error("read data outside read answer");
    reset_quiet_a: assert property ($rose(RSTN) |-> !PREADY && !REF_WAVE && !CHAN_OUT)
        else $error("outputs not quiet after reset");
    force_high_a: assert property (age_reg == 2'h3 && ctrl_reg[2:0] == `MD_FORCE_HI |-> REF_WAVE)
        else $error("forced high not high");
    force_low_a: assert property (age_reg == 2'h3 && ctrl_reg[2:0] == `MD_FORCE_LO |-> !REF_WAVE)
        else $error("forced low not low");
    force_pin_a: assert property (age_reg == 2'h3 && ctrl_reg[2:0] == `MD_FORCE_HI
        |-> CHAN_OUT == (ctrl_reg[`CT_OEN] && !ctrl_reg[`CT_POL]))
        else $error("pin not inverse of polarity");
    out_enable_a: assert property (age_reg == 2'h3 |-> CHAN_OUT_EN == ctrl_reg[`CT_OEN])
        else $error("output enable mismatch");
    // Main scenarios reached
    cover property (wr_ctrl);
    cover property (PREADY && PSLVERR);
    cover property (age_reg == 2'h3 && ctrl_reg[2:0] == `MD_FORCE_HI);
endmodule // oc_channel_monitor
bind oc_channel oc_channel_monitor i_oc_channel_monitor (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .REF_WAVE(REF_WAVE),
    .CHAN_OUT(CHAN_OUT), .CHAN_OUT_EN(CHAN_OUT_EN));
`default_nettype wire

// File: tb/pin_load_model.sv
// Load on the channel pin: a pull-down holds the line when released.
// Assumes the channel drives the pin only while its enable is high.
`timescale 1ns/10ps
`default_nettype none
module pin_load_model (
    // Channel side
    input  wire logic drive,
    input  wire logic drive_en,
    // Line as the load sees it
    output var  logic pin
);
    // Released line falls to the pull-down, never keeps the last level
    assign pin = drive_en ? drive : 1'b0;
endmodule // pin_load_model
`default_nettype wire

// File: tb/oc_channel_test.sv
// Testbench for the compare channel: APB calls with expected values.
// Assumes oc_channel, the checker bound to it and the pin load model.
`timescale 1ns/10ps
`default_nettype none
`include "oc_channel_defines.vh"
module oc_channel_test;
    localparam logic [31:0] RUN = 32'h0000_1000, OEN = 32'h0000_4000, POL = 32'h0000_2000;
    localparam logic [31:0] ONEP = 32'h0000_0400, DIR = 32'h0000_0200, IRQ = 32'h0000_0040;
    localparam logic [31:0] CLR = 32'h0000_0020, PRE = 32'h0000_0808;
    localparam logic [31:0] FST = 32'h0000_0010, CDN = 32'h0000_0080;
    logic        REF_CLK, RSTN, PSEL, PENABLE, PWRITE, TRIG_IN, EXT_TRIG_IN;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, q;
    logic        PREADY, PSLVERR, REF_WAVE, CHAN_OUT, CHAN_OUT_EN, MATCH_IRQ, e, pin;
    int          errors, n_checks;
    // Per row: control word, compare value, high cycles in a 10-cycle period
    logic [31:0] pc [6] = '{RUN | `MD_PWM1, 4, 0, RUN | `MD_PWM2, RUN | `MD_PWM1,
                            RUN | `MD_PWM2};
    int          pv [6] = '{4, 0, 12, 4, 4, 12};
    int          px [6] = '{4, 0, 10, 6, 5, 10};
    oc_channel #(.W(16)) i_oc_channel (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_IN(TRIG_IN), .EXT_TRIG_IN(EXT_TRIG_IN),
        .REF_WAVE(REF_WAVE), .CHAN_OUT(CHAN_OUT), .CHAN_OUT_EN(CHAN_OUT_EN),
        .MATCH_IRQ(MATCH_IRQ));
    pin_load_model i_pin_load_model (.drive(CHAN_OUT), .drive_en(CHAN_OUT_EN), .pin(pin));
    // ==========
    // Clock, and a watchdog far beyond the expected run length
    initial
    begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        errors++;
        end_sim();
    end
    // ==========
    // Tasks
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", s, x, g);
        end
    endtask
    // One APB transfer; held until ready is sampled high, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        // No local limit: only the watchdog may end a wait for the answer
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0000_0000);
        chk(s, q, x);
    endtask
    task automatic ref_after(input int c, input logic x);
        repeat (c) @(posedge REF_CLK);
        chk("ref", REF_WAVE, x);
    endtask
    task automatic duty(input int x);
        int h;
        h = 0;
        repeat (10)
        begin
            @(posedge REF_CLK);
            h += (REF_WAVE === 1'b1);
        end
        chk("duty", h, x);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial
    begin
        {RSTN, PSEL, PENABLE, PWRITE, TRIG_IN, EXT_TRIG_IN} = 6'h00;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
        repeat (5) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
        rdc(`OFS_CTRL, 32'h0000_0000, "ctrl");
        rdc(`OFS_RELOAD, 32'h0000_FFFF, "reload");
        rdc(`OFS_COMPARE, 32'h0000_0000, "compare");
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("slverr", e, 1'b1);
        // Forced high still matches and interrupts; forced low with polarity
        wr(`OFS_RELOAD, 32'h0000_000A);
        wr(`OFS_COMPARE, 32'h0000_0003);
        wr(`OFS_CTRL, `MD_FORCE_HI | OEN | IRQ | RUN);
        ref_after(30, 1'b1);
        chk("pin", pin, 1'b1);
        chk("irq", MATCH_IRQ, 1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk("flag", q[`ST_FLAG], 1'b1);
        wr(`OFS_CTRL, `MD_FORCE_LO | OEN | POL);
        ref_after(3, 1'b0);
        chk("pin", pin, 1'b1);
        chk("irq", MATCH_IRQ, 1'b0);
        // Compare modes in single pulse: one match, then the counter stops
        for (int m = 0; m < 4; m++)
        begin
            wr(`OFS_CTRL, (m == 2) ? `MD_FORCE_HI : `MD_FORCE_LO);
            wr(`OFS_COUNT, 32'h0000_0000);
            wr(`OFS_CTRL, m | ONEP);
            TRIG_IN <= 1'b1;
            repeat (4) @(posedge REF_CLK);
            TRIG_IN <= 1'b0;
            ref_after(40, m[0]);
            rdc(`OFS_CTRL, m | ONEP, "run");
            repeat (2) rdc(`OFS_COUNT, 32'h0000_0000, "stopped");
        end
        // PWM duty over one full period
        wr(`OFS_RELOAD, 32'h0000_0009);
        pc[1] = pc[0];
        pc[2] = pc[0];
        pc[4] = pc[0] | DIR;
        pc[5] = pc[4];
        for (int i = 0; i < 6; i++)
        begin
            wr(`OFS_COMPARE, pv[i]);
            wr(`OFS_CTRL, pc[i]);
            repeat (25) @(posedge REF_CLK);
            duty(px[i]);
        end
        // Preload off acts at once, on waits for an update
        wr(`OFS_CTRL, `MD_PWM1);
        wr(`OFS_COMPARE, 32'h0000_0004);
        wr(`OFS_COUNT, 32'h0000_0006);
        ref_after(3, 1'b0);
        wr(`OFS_COMPARE, 32'h0000_0008);
        ref_after(3, 1'b1);
        wr(`OFS_CTRL, `MD_PWM1 | PRE);
        wr(`OFS_COMPARE, 32'h0000_0002);
        ref_after(3, 1'b1);
        wr(`OFS_EVENT, 32'h0000_0001);
        wr(`OFS_COUNT, 32'h0000_0006);
        ref_after(3, 1'b0);
        // Trigger level clears the PWM reference until the next update; forced high stays high
        wr(`OFS_CTRL, `MD_PWM1 | CLR);
        wr(`OFS_COMPARE, 32'h0000_000C);
        ref_after(3, 1'b1);
        EXT_TRIG_IN <= 1'b1;
        ref_after(6, 1'b0);
        EXT_TRIG_IN <= 1'b0;
        ref_after(6, 1'b0);
        wr(`OFS_EVENT, 32'h0000_0001);
        ref_after(3, 1'b1);
        wr(`OFS_CTRL, `MD_FORCE_HI | CLR);
        EXT_TRIG_IN <= 1'b1;
        ref_after(6, 1'b1);
        EXT_TRIG_IN <= 1'b0;
        // Fast enable: a software trigger jumps PWM2 to its after-match level
        wr(`OFS_CTRL, `MD_PWM2 | FST | ONEP);
        ref_after(2, 1'b0);
        wr(`OFS_EVENT, 32'h0000_0002);
        chk("fast", REF_WAVE, 1'b1);
        // Center mode, flag on the down slope only; count writes steer direction
        wr(`OFS_COMPARE, 32'h0000_0004);
        wr(`OFS_CTRL, `MD_PWM1 | CDN | ONEP);
        wr(`OFS_COUNT, 32'h0000_0009);
        rdc(`OFS_CTRL, `MD_PWM1 | CDN | ONEP | DIR, "dir");
        wr(`OFS_COUNT, 32'h0000_0000);
        rdc(`OFS_CTRL, `MD_PWM1 | CDN | ONEP, "dir");
        wr(`OFS_STATUS, 32'h0000_0001);
        wr(`OFS_EVENT, 32'h0000_0002);
        repeat (15) @(posedge REF_CLK);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk("flag", q[`ST_FLAG], 1'b0);
        wr(`OFS_EVENT, 32'h0000_0002);
        repeat (15) @(posedge REF_CLK);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk("flag", q[`ST_FLAG], 1'b1);
        end_sim();
    end
endmodule // oc_channel_test
`default_nettype wire
